// File: rtl/fbio_regs.svh
// register offsets, bit positions, reset values and timing figures of the fieldbus word handler
`ifndef FBIO_REGS_SVH
`define FBIO_REGS_SVH

// clock rate of pclk in hertz
`define FBIO_CLK_HZ 25000000

// apb byte offsets of the six output words (written by the fieldbus side)
`define FBIO_OUT_W1_OFS 8'h00
`define FBIO_OUT_W2_OFS 8'h04
`define FBIO_OUT_W3_OFS 8'h08
`define FBIO_OUT_W4_OFS 8'h0C
`define FBIO_OUT_W5_OFS 8'h10
`define FBIO_OUT_W6_OFS 8'h14
// apb byte offsets of the input words three to six (read only)
`define FBIO_IN_W3_OFS 8'h18
`define FBIO_IN_W4_OFS 8'h1C
`define FBIO_IN_W5_OFS 8'h20
`define FBIO_IN_W6_OFS 8'h24
// word count configuration and parameter write status
`define FBIO_WCNT_OFS 8'h28
`define FBIO_WR_STAT_OFS 8'h2C

// word count choices and reset value
`define FBIO_WCNT_TWO 3'h2
`define FBIO_WCNT_FOUR 3'h4
`define FBIO_WCNT_SIX 3'h6
`define FBIO_WCNT_RST 3'h6

// parameter numbers and codes
`define FBIO_PARAM_IDLE 16'h03E7
`define FBIO_PNUM_CTRL_MODE 16'h00CA
`define FBIO_PNUM_CTRL_LOAD 16'h00CC
`define FBIO_PNUM_SELF_TUNE 16'h0198
`define FBIO_VECTOR_MODE_MIN 16'h0003

// logical command value bits; the mask bit sits this far above its value bit
`define FBIO_CMD_MASK_OFS 8
`define FBIO_BIT_RUN 0
`define FBIO_BIT_ENABLE 1
`define FBIO_BIT_FORWARD 2
`define FBIO_BIT_JOG 3
`define FBIO_BIT_REMOTE 4
`define FBIO_BIT_NOSAVE 5
`define FBIO_BIT_FRESET 7

// digital output and input widths, output control bits start here
`define FBIO_DOUT_NUM 7
`define FBIO_DOUT_CTRL_OFS 8
`define FBIO_DI_NUM 10

// reset values of held commands
`define FBIO_CMD_RST 1'b0
`define FBIO_FWD_RST 1'b1
`define FBIO_SAVE_RST 1'b1

// timing figures: value hold time in ms, filter time constants in s
`define FBIO_HOLD_MS 15.0
`define FBIO_TRQ_TAU_S 0.5
`define FBIO_CUR_TAU_S 0.3
`define FBIO_LPF_SHIFT 8

`endif

// File: rtl/fbio_pkg.sv
// types shared by the fieldbus word handler
package fbio_pkg;
   // parameter write sequencer states
   typedef enum logic [1:0] {
      FBIO_WR_IDLE,
      FBIO_WR_WAIT,
      FBIO_WR_DONE
   } fbio_wr_state_type;

   typedef logic [15:0] fbio_word_type;
endpackage : fbio_pkg

// File: rtl/fbio_lpf.sv
// first-order low-pass filter for a signed 16-bit monitored value
`timescale 1ns/1ps
`include "fbio_regs.svh"
module fbio_lpf #(
   parameter int DIV = 48828
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic signed [15:0] sample,
   output logic signed [15:0] filtered
);
   // accumulator holds the output with extra fraction bits
   logic signed [23:0] acc_r, acc_nxt;
   logic [23:0] div_cnt_r, div_cnt_nxt;
   logic signed [24:0] diff;

   // step toward the sample by 1/256 once every DIV cycles; tau = DIV * 256 cycles
   always_comb
   begin
      diff = 25'($signed({sample, 8'h00})) - 25'(acc_r);
      div_cnt_nxt = div_cnt_r + 24'h00_0001;
      acc_nxt = acc_r;
      if (div_cnt_r == 24'(DIV - 1))
      begin
         div_cnt_nxt = 24'h00_0000;
         acc_nxt = acc_r + 24'(diff >>> `FBIO_LPF_SHIFT);
      end
   end

   // register the filter state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc_r <= 24'sh00_0000;
         div_cnt_r <= 24'h00_0000;
      end
      else
      begin
         acc_r <= acc_nxt;
         div_cnt_r <= div_cnt_nxt;
      end
   end

   // integer part only; the fraction is dropped
   assign filtered = acc_r[23:8];
endmodule : fbio_lpf

// File: rtl/fbio_word_handler.sv
// fieldbus cyclic i/o word handler with apb access to the exchanged words
`timescale 1ns/1ps
`include "fbio_regs.svh"
module fbio_word_handler #(
   parameter int HOLD_CYCLES = int'($ceil(`FBIO_HOLD_MS * `FBIO_CLK_HZ / 1000.0)),
   parameter int TRQ_DIV = int'(`FBIO_TRQ_TAU_S * `FBIO_CLK_HZ) >> `FBIO_LPF_SHIFT,
   parameter int CUR_DIV = int'(`FBIO_CUR_TAU_S * `FBIO_CLK_HZ) >> `FBIO_LPF_SHIFT
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [9:0] digital_inputs,
   input wire logic signed [15:0] motor_torque_param,
   input wire logic signed [15:0] motor_current_param,
   output logic [15:0] param_rd_num,
   input wire logic [15:0] param_rd_data,
   output logic param_wr_req,
   output logic [15:0] param_wr_num,
   output logic [15:0] param_wr_value,
   input wire logic control_mode_vector,
   input wire logic motor_model_zero,
   input wire logic [15:0] max_speed_ref,
   output logic [15:0] speed_ref,
   output logic cmd_run,
   output logic cmd_enable,
   output logic cmd_forward,
   output logic cmd_jog,
   output logic cmd_remote,
   output logic fault_reset,
   output logic nv_save_en,
   input wire logic [6:0] fb_output_assigned,
   output logic [6:0] fb_outputs
);
   // apb side state
   fbio_pkg::fbio_word_type out_w_r [0:5];
   fbio_pkg::fbio_word_type out_w_nxt [0:5];
   logic [2:0] wcnt_r, wcnt_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic slverr_r, slverr_nxt;
   // input words three to six as seen by the master
   fbio_pkg::fbio_word_type in_w3_r, in_w3_nxt, in_w4_r, in_w4_nxt;
   fbio_pkg::fbio_word_type in_w5_r, in_w5_nxt, in_w6_r, in_w6_nxt;
   logic signed [15:0] trq_filt, cur_filt;
   // held drive commands
   logic run_r, run_nxt, ena_r, ena_nxt, fwd_r, fwd_nxt, jog_r, jog_nxt;
   logic rem_r, rem_nxt, save_r, save_nxt, frst_r, frst_nxt, b7_prev_r, b7_prev_nxt;
   logic [15:0] spd_r, spd_nxt;
   logic [6:0] dout_r, dout_nxt;
   // parameter write sequencer
   fbio_pkg::fbio_wr_state_type wr_st_r, wr_st_nxt;
   logic [23:0] hold_cnt_r, hold_cnt_nxt;
   logic [15:0] snap_num_r, snap_num_nxt, snap_val_r, snap_val_nxt;
   logic wr_req_r, wr_req_nxt, refused_r, refused_nxt, done_r, done_nxt;
   logic have4, have6, wr_active, refuse, changed;
   logic [9:0] di_word;
   logic apb_wr;

   // which optional words take part in the exchange
   assign have4 = (wcnt_r != `FBIO_WCNT_TWO);
   assign have6 = (wcnt_r == `FBIO_WCNT_SIX);
   assign apb_wr = psel && penable && pwrite;

   // apb: writes land in the access phase, read data is captured in setup
   always_comb
   begin
      for (int i = 0; i < 6; i++)
      begin
         out_w_nxt[i] = out_w_r[i];
      end
      wcnt_nxt = wcnt_r;
      prdata_nxt = prdata_r;
      slverr_nxt = 1'b0;
      if (apb_wr && !slverr_r)
      begin
         if (paddr <= `FBIO_OUT_W6_OFS && paddr[1:0] == 2'b00)
         begin
            out_w_nxt[paddr[4:2]] = pwdata[15:0];
         end
         else if (paddr == `FBIO_WCNT_OFS)
         begin
            // other counts are dropped so both sides keep a legal size
            if (pwdata[2:0] == `FBIO_WCNT_TWO || pwdata[2:0] == `FBIO_WCNT_FOUR ||
                pwdata[2:0] == `FBIO_WCNT_SIX)
            begin
               wcnt_nxt = pwdata[2:0];
            end
         end
      end
      if (psel && !penable)
      begin
         prdata_nxt = 32'h0000_0000;
         if (paddr <= `FBIO_OUT_W6_OFS && paddr[1:0] == 2'b00)
         begin
            prdata_nxt = {16'h0000, out_w_r[paddr[4:2]]};
         end
         else if (paddr == `FBIO_IN_W3_OFS)
         begin
            prdata_nxt = {16'h0000, in_w3_r};
         end
         else if (paddr == `FBIO_IN_W4_OFS)
         begin
            prdata_nxt = {16'h0000, in_w4_r};
         end
         else if (paddr == `FBIO_IN_W5_OFS)
         begin
            prdata_nxt = {16'h0000, in_w5_r};
         end
         else if (paddr == `FBIO_IN_W6_OFS)
         begin
            prdata_nxt = {16'h0000, in_w6_r};
         end
         else if (paddr == `FBIO_WCNT_OFS)
         begin
            prdata_nxt = {29'h0000_0000, wcnt_r};
         end
         else if (paddr == `FBIO_WR_STAT_OFS)
         begin
            prdata_nxt = {28'h000_0000, 1'b0, wr_st_r == fbio_pkg::FBIO_WR_WAIT,
                          done_r, refused_r};
         end
         else
         begin
            slverr_nxt = 1'b1; // unmapped offset
         end
      end
      else if (psel)
      begin
         slverr_nxt = slverr_r;
      end
   end

   // apb registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < 6; i++)
         begin
            out_w_r[i] <= 16'h0000;
         end
         wcnt_r <= `FBIO_WCNT_RST;
         prdata_r <= 32'h0000_0000;
         slverr_r <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < 6; i++)
         begin
            out_w_r[i] <= out_w_nxt[i];
         end
         wcnt_r <= wcnt_nxt;
         prdata_r <= prdata_nxt;
         slverr_r <= slverr_nxt;
      end
   end

   // zero wait states; error only shows in the access phase
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = slverr_r && psel && penable;

   // input one sits at bit 7 down to input eight at bit 0
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_di
         assign di_word[g] = digital_inputs[7 - g];
      end
   endgenerate
   assign di_word[9:8] = digital_inputs[9:8];

   // monitored values through their filters
   fbio_lpf #(.DIV(TRQ_DIV)) u_trq_lpf (
      .pclk(pclk),
      .presetn(presetn),
      .sample(motor_torque_param),
      .filtered(trq_filt)
   );
   fbio_lpf #(.DIV(CUR_DIV)) u_cur_lpf (
      .pclk(pclk),
      .presetn(presetn),
      .sample(motor_current_param),
      .filtered(cur_filt)
   );

   // input words; words outside the configured count read zero
   always_comb
   begin
      in_w3_nxt = have4 ? {6'h00, di_word} : 16'h0000;
      in_w4_nxt = have4 ? param_rd_data : 16'h0000;
      in_w5_nxt = have6 ? trq_filt : 16'h0000;
      in_w6_nxt = have6 ? cur_filt : 16'h0000;
   end

   // input word registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         in_w3_r <= 16'h0000;
         in_w4_r <= 16'h0000;
         in_w5_r <= 16'h0000;
         in_w6_r <= 16'h0000;
      end
      else
      begin
         in_w3_r <= in_w3_nxt;
         in_w4_r <= in_w4_nxt;
         in_w5_r <= in_w5_nxt;
         in_w6_r <= in_w6_nxt;
      end
   end

   // read selector goes straight out; content returns next cycle
   assign param_rd_num = have4 ? out_w_r[3] : 16'h0000;

   // logical command: each value bit applies only while its mask bit is 1
   always_comb
   begin
      run_nxt = out_w_r[0][`FBIO_BIT_RUN + `FBIO_CMD_MASK_OFS] ?
                out_w_r[0][`FBIO_BIT_RUN] : run_r;
      ena_nxt = out_w_r[0][`FBIO_BIT_ENABLE + `FBIO_CMD_MASK_OFS] ?
                out_w_r[0][`FBIO_BIT_ENABLE] : ena_r;
      fwd_nxt = out_w_r[0][`FBIO_BIT_FORWARD + `FBIO_CMD_MASK_OFS] ?
                out_w_r[0][`FBIO_BIT_FORWARD] : fwd_r;
      jog_nxt = out_w_r[0][`FBIO_BIT_JOG + `FBIO_CMD_MASK_OFS] ?
                out_w_r[0][`FBIO_BIT_JOG] : jog_r;
      rem_nxt = out_w_r[0][`FBIO_BIT_REMOTE + `FBIO_CMD_MASK_OFS] ?
                out_w_r[0][`FBIO_BIT_REMOTE] : rem_r;
      // bit 5 low means save; held so writers of limits can stop wear
      save_nxt = out_w_r[0][`FBIO_BIT_NOSAVE + `FBIO_CMD_MASK_OFS] ?
                 !out_w_r[0][`FBIO_BIT_NOSAVE] : save_r;
      // one-cycle reset pulse on a rising value bit under its mask
      frst_nxt = out_w_r[0][`FBIO_BIT_FRESET + `FBIO_CMD_MASK_OFS] &&
                 out_w_r[0][`FBIO_BIT_FRESET] && !b7_prev_r;
      b7_prev_nxt = out_w_r[0][`FBIO_BIT_FRESET];
      // 8191 is synchronous speed; larger values pass up to the ceiling
      spd_nxt = (out_w_r[1] > max_speed_ref) ? max_speed_ref : out_w_r[1];
   end

   // command registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_r <= `FBIO_CMD_RST;
         ena_r <= `FBIO_CMD_RST;
         fwd_r <= `FBIO_FWD_RST;
         jog_r <= `FBIO_CMD_RST;
         rem_r <= `FBIO_CMD_RST;
         save_r <= `FBIO_SAVE_RST;
         frst_r <= 1'b0;
         b7_prev_r <= 1'b0;
         spd_r <= 16'h0000;
      end
      else
      begin
         run_r <= run_nxt;
         ena_r <= ena_nxt;
         fwd_r <= fwd_nxt;
         jog_r <= jog_nxt;
         rem_r <= rem_nxt;
         save_r <= save_nxt;
         frst_r <= frst_nxt;
         b7_prev_r <= b7_prev_nxt;
         spd_r <= spd_nxt;
      end
   end

   // fieldbus outputs: only assigned outputs whose control bit is set follow
   generate
      for (g = 0; g < `FBIO_DOUT_NUM; g++)
      begin : g_dout
         always_comb
         begin
            dout_nxt[g] = (have4 && fb_output_assigned[g] &&
                          out_w_r[2][g + `FBIO_DOUT_CTRL_OFS]) ?
                          out_w_r[2][g] : dout_r[g];
         end
      end
   endgenerate

   // fieldbus output register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dout_r <= 7'h00;
      end
      else
      begin
         dout_r <= dout_nxt;
      end
   end

   // parameter write: idle code means nothing; a pair is taken once stable for the hold time
   assign wr_active = have6 && (out_w_r[4] != `FBIO_PARAM_IDLE);
   assign changed = (out_w_r[4] != snap_num_r) || (out_w_r[5] != snap_val_r);
   assign refuse = (snap_num_r == `FBIO_PNUM_CTRL_LOAD) ||
                   (snap_num_r == `FBIO_PNUM_SELF_TUNE) ||
                   ((snap_num_r == `FBIO_PNUM_CTRL_MODE) && !control_mode_vector &&
                    (snap_val_r >= `FBIO_VECTOR_MODE_MIN) && motor_model_zero);

   // sequencer next state
   always_comb
   begin
      wr_st_nxt = wr_st_r;
      hold_cnt_nxt = hold_cnt_r;
      snap_num_nxt = snap_num_r;
      snap_val_nxt = snap_val_r;
      wr_req_nxt = 1'b0;
      refused_nxt = refused_r;
      done_nxt = done_r;
      case (wr_st_r)
         fbio_pkg::FBIO_WR_IDLE:
         begin
            if (wr_active)
            begin
               wr_st_nxt = fbio_pkg::FBIO_WR_WAIT;
               hold_cnt_nxt = 24'h00_0000;
               snap_num_nxt = out_w_r[4];
               snap_val_nxt = out_w_r[5];
               refused_nxt = 1'b0;
               done_nxt = 1'b0;
            end
         end
         fbio_pkg::FBIO_WR_WAIT:
         begin
            if (!wr_active)
            begin
               wr_st_nxt = fbio_pkg::FBIO_WR_IDLE;
            end
            else if (changed)
            begin
               // a new pair restarts the hold time
               hold_cnt_nxt = 24'h00_0000;
               snap_num_nxt = out_w_r[4];
               snap_val_nxt = out_w_r[5];
            end
            else if (hold_cnt_r == 24'(HOLD_CYCLES - 1))
            begin
               wr_st_nxt = fbio_pkg::FBIO_WR_DONE;
               refused_nxt = refuse;
               done_nxt = !refuse;
               wr_req_nxt = !refuse;
            end
            else
            begin
               hold_cnt_nxt = hold_cnt_r + 24'h00_0001;
            end
         end
         fbio_pkg::FBIO_WR_DONE:
         begin
            if (!wr_active)
            begin
               wr_st_nxt = fbio_pkg::FBIO_WR_IDLE;
            end
            else if (changed)
            begin
               wr_st_nxt = fbio_pkg::FBIO_WR_WAIT;
               hold_cnt_nxt = 24'h00_0000;
               snap_num_nxt = out_w_r[4];
               snap_val_nxt = out_w_r[5];
            end
         end
         default:
         begin
            wr_st_nxt = fbio_pkg::FBIO_WR_IDLE;
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_st_r <= fbio_pkg::FBIO_WR_IDLE;
         hold_cnt_r <= 24'h00_0000;
         snap_num_r <= `FBIO_PARAM_IDLE;
         snap_val_r <= 16'h0000;
         wr_req_r <= 1'b0;
         refused_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         wr_st_r <= wr_st_nxt;
         hold_cnt_r <= hold_cnt_nxt;
         snap_num_r <= snap_num_nxt;
         snap_val_r <= snap_val_nxt;
         wr_req_r <= wr_req_nxt;
         refused_r <= refused_nxt;
         done_r <= done_nxt;
      end
   end

   assign param_wr_req = wr_req_r;
   assign param_wr_num = snap_num_r;
   assign param_wr_value = snap_val_r;
   assign speed_ref = spd_r;
   assign cmd_run = run_r;
   assign cmd_enable = ena_r;
   assign cmd_forward = fwd_r;
   assign cmd_jog = jog_r;
   assign cmd_remote = rem_r;
   assign fault_reset = frst_r;
   assign nv_save_en = save_r;
   assign fb_outputs = dout_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_di_map: assert property (have4 |=> in_w3_r[9] == $past(digital_inputs[9]) &&
      in_w3_r[7] == $past(digital_inputs[0]) && in_w3_r[0] == $past(digital_inputs[7]))
      else $error("input word three mapping wrong");
   chk_param_read: assert property (have4 ##1 have4 |-> in_w4_r == $past(param_rd_data))
      else $error("read parameter content not returned");
   chk_mask_hold: assert property (!out_w_r[0][9] |=> cmd_enable == $past(cmd_enable))
      else $error("enable changed without its mask");
   chk_run_apply: assert property (out_w_r[0][8] |=> cmd_run == $past(out_w_r[0][0]))
      else $error("masked run value not applied");
   chk_fault_edge: assert property ((out_w_r[0][15] && out_w_r[0][7] && !b7_prev_r)
      |=> fault_reset ##1 !fault_reset || $past(out_w_r[0][7]) != out_w_r[0][7])
      else $error("fault reset edge not pulsed");
   chk_save_gate: assert property (out_w_r[0][13] |=> nv_save_en == !$past(out_w_r[0][5]))
      else $error("save enable does not follow bit five");
   chk_speed_cap: assert property (1'b1 |=> speed_ref <= $past(max_speed_ref) &&
      (speed_ref == $past(out_w_r[1]) || speed_ref == $past(max_speed_ref)))
      else $error("speed reference not clamped");
   chk_dout_ctrl: assert property ((have4 && fb_output_assigned[0] && out_w_r[2][8])
      |=> fb_outputs[0] == $past(out_w_r[2][0]))
      else $error("assigned output ignores its command");
   chk_idle_write: assert property (param_wr_req |-> $past(wr_active) &&
      param_wr_num != `FBIO_PARAM_IDLE)
      else $error("write issued on idle code");
   chk_local_only: assert property (param_wr_req |-> param_wr_num != `FBIO_PNUM_CTRL_LOAD &&
      param_wr_num != `FBIO_PNUM_SELF_TUNE)
      else $error("local-only parameter written");
endmodule : fbio_word_handler

// File: sim/fbio_param_store.sv
// parameter store model on the far side of the read selector and write pulse
`timescale 1ns/1ps
module fbio_param_store
(
   input wire logic pclk,
   input wire logic [15:0] param_rd_num,
   output logic [15:0] param_rd_data,
   input wire logic param_wr_req,
   input wire logic [15:0] param_wr_num,
   input wire logic [15:0] param_wr_value
);
   logic [15:0] mem [0:255]; // low byte of the number picks the slot
   // unwritten slots hold a pattern the bench can predict
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 16'(i) ^ 16'h5a5a;
   end
   // only a write pulse commits the pair
   always @(posedge pclk)
   begin
      if (param_wr_req)
         mem[param_wr_num[7:0]] <= param_wr_value;
   end
   // content follows the selector at once
   assign param_rd_data = mem[param_rd_num[7:0]];
endmodule : fbio_param_store

// File: sim/test_fieldbus_io_word_handler.sv
// self-checking bench of the fieldbus word handler
`timescale 1ns/1ps
`include "fbio_regs.svh"
module test_fieldbus_io_word_handler;
   localparam int HOLD = 16; // shortened hold time keeps the run short
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [9:0] digital_inputs = 10'h000;
   logic signed [15:0] motor_torque_param = 16'h0000, motor_current_param = 16'h0000;
   logic control_mode_vector = 1'b0, motor_model_zero = 1'b0;
   logic [15:0] max_speed_ref = 16'hffff;
   logic [6:0] fb_output_assigned = 7'h7f;
   logic [31:0] prdata, rdat, seed;
   logic pready, pslverr, param_wr_req, cmd_run, cmd_enable, cmd_forward, cmd_jog;
   logic cmd_remote, fault_reset, nv_save_en, rerr;
   logic [15:0] param_rd_num, param_rd_data, param_wr_num, param_wr_value, speed_ref;
   logic [6:0] fb_outputs, a, e_out;
   logic [4:0] e_cmd = 5'h04; // forward only after reset
   logic e_nv = 1'b1;
   logic [15:0] w1, w2, w3, m;
   logic [15:0] cw [5] = '{16'h1f1f, 16'h1f00, 16'h2020, 16'h2000, 16'h0a1f};
   int n_errors = 0, n_tests = 0, cnt;

   fbio_word_handler #(.HOLD_CYCLES(HOLD), .TRQ_DIV(2), .CUR_DIV(1)) u_dut
   (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .digital_inputs, .motor_torque_param, .motor_current_param,
      .param_rd_num, .param_rd_data, .param_wr_req, .param_wr_num, .param_wr_value,
      .control_mode_vector, .motor_model_zero, .max_speed_ref, .speed_ref, .cmd_run,
      .cmd_enable, .cmd_forward, .cmd_jog, .cmd_remote, .fault_reset, .nv_save_en,
      .fb_output_assigned, .fb_outputs
   );
   fbio_param_store u_store
   (
      .pclk, .param_rd_num, .param_rd_data, .param_wr_req, .param_wr_num, .param_wr_value
   );

   // 25 mhz bus clock
   always #20 pclk = ~pclk;

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         n_errors++;
         end_of_test();
      end
   endtask : apb

   // input one lands at bit 7, input eight at bit 0, nine and ten stay put
   function automatic logic [31:0] f_di(input logic [9:0] d);
      f_di = {22'h00_0000, d[9:8], 8'h00};
      for (int k = 0; k < 8; k++)
         f_di[7 - k] = d[k];
   endfunction : f_di

   function automatic logic [4:0] f_cmd(input logic [4:0] o, input logic [15:0] w);
      for (int k = 0; k < 5; k++)
         if (w[8 + k])
            o[k] = w[k];
      return o;
   endfunction : f_cmd

   function automatic logic [6:0] f_out(input logic [6:0] o, input logic [15:0] w,
                                        input logic [6:0] s);
      for (int k = 0; k < 7; k++)
         if (w[8 + k] && s[k])
            o[k] = w[k];
      return o;
   endfunction : f_out

   // command word write followed by a check of all held commands
   task automatic cmd(input logic [15:0] w);
      apb(1'b1, `FBIO_OUT_W1_OFS, 32'(w));
      e_cmd = f_cmd(e_cmd, w);
      if (w[13])
         e_nv = ~w[5];
      repeat (3) @(posedge pclk);
      chk("cmds", {cmd_remote, cmd_jog, cmd_forward, cmd_enable, cmd_run}, 32'(e_cmd));
      chk("save", nv_save_en, 32'(e_nv));
   endtask : cmd

   // counts fault reset pulses after a command word
   task automatic fr(input logic [15:0] w, input int exp);
      apb(1'b1, `FBIO_OUT_W1_OFS, 32'(w));
      cnt = 0;
      repeat (4)
      begin
         @(posedge pclk);
         cnt += fault_reset;
      end
      chk("fault reset", 32'(cnt), 32'(exp));
   endtask : fr

   // parameter write; master holds the pair and restores the idle code
   task automatic pw(input logic [15:0] num, input logic [15:0] val, input int exp);
      apb(1'b1, `FBIO_OUT_W6_OFS, 32'(val));
      apb(1'b1, `FBIO_OUT_W5_OFS, 32'(num));
      cnt = 0;
      repeat (HOLD + 30)
      begin
         @(posedge pclk);
         if (param_wr_req === 1'b1)
         begin
            cnt++;
            chk("wr pair", {param_wr_num, param_wr_value}, {num, val});
         end
      end
      chk("wr pulses", 32'(cnt), 32'(exp));
      apb(1'b0, `FBIO_WR_STAT_OFS, 32'h0000_0000);
      if (num != `FBIO_PARAM_IDLE)
         chk("refused", rdat[0], 32'(exp == 0));
      apb(1'b1, `FBIO_OUT_W5_OFS, 32'(`FBIO_PARAM_IDLE));
   endtask : pw

   initial
   begin
      seed = 32'h0000_c35f;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      chk("idle num", param_wr_num, 32'(`FBIO_PARAM_IDLE));
      apb(1'b1, `FBIO_OUT_W5_OFS, 32'(`FBIO_PARAM_IDLE));
      apb(1'b0, `FBIO_WCNT_OFS, 32'h0000_0000);
      chk("count", rdat, 32'h0000_0006);
      apb(1'b1, `FBIO_WCNT_OFS, 32'h0000_0005);
      apb(1'b1, `FBIO_WCNT_OFS, 32'h0000_0002);
      apb(1'b0, `FBIO_WCNT_OFS, 32'h0000_0000);
      chk("count", rdat, 32'h0000_0002);
      apb(1'b1, `FBIO_OUT_W4_OFS, 32'h0000_0033);
      apb(1'b1, `FBIO_OUT_W3_OFS, 32'h0000_7f7f);
      repeat (3) @(posedge pclk);
      chk("short rd num", param_rd_num, 32'h0000_0000);
      chk("short outs", fb_outputs, 32'h0000_0000);
      apb(1'b1, `FBIO_WCNT_OFS, 32'h0000_0006);
      w3 = 16'h7f00;
      e_out = 7'h00;
      apb(1'b1, `FBIO_OUT_W3_OFS, 32'(w3));
      $display("test word count done");
      // every command both ways, then the save corner
      foreach (cw[i])
         cmd(cw[i]);
      // random words with speed corners and random output words
      for (int i = 0; i < 24; i++)
      begin
         w1 = 16'($random(seed));
         w2 = (i == 0) ? 16'h1fff : 16'($random(seed));
         m = (i == 1) ? 16'h1fff : 16'($random(seed));
         a = 7'($random(seed));
         @(posedge pclk);
         digital_inputs <= 10'($random(seed));
         max_speed_ref <= m;
         fb_output_assigned <= a;
         e_out = f_out(e_out, w3, a);
         w3 = 16'($random(seed));
         e_out = f_out(e_out, w3, a);
         apb(1'b1, `FBIO_OUT_W2_OFS, 32'(w2));
         apb(1'b1, `FBIO_OUT_W3_OFS, 32'(w3));
         cmd(w1);
         chk("speed", speed_ref, 32'((w2 > m) ? m : w2));
         chk("outs", fb_outputs, 32'(e_out));
         apb(1'b0, `FBIO_IN_W3_OFS, 32'h0000_0000);
         chk("inputs", rdat, f_di(digital_inputs));
      end
      $display("test commands done");
      fr(16'h0000, 0);
      fr(16'h0080, 0);
      fr(16'h8080, 0);
      fr(16'h8000, 0);
      fr(16'h8080, 1);
      $display("test fault reset done");
      apb(1'b1, `FBIO_OUT_W4_OFS, 32'h0000_0021);
      apb(1'b0, `FBIO_IN_W4_OFS, 32'h0000_0000);
      chk("param read", rdat, 32'h0000_5a7b);
      pw(16'h0021, 16'h1234, 1);
      apb(1'b0, `FBIO_IN_W4_OFS, 32'h0000_0000);
      chk("param back", rdat, 32'h0000_1234);
      pw(`FBIO_PNUM_CTRL_LOAD, 16'h0001, 0);
      pw(`FBIO_PNUM_SELF_TUNE, 16'h0001, 0);
      motor_model_zero <= 1'b1;
      pw(`FBIO_PNUM_CTRL_MODE, 16'h0003, 0);
      motor_model_zero <= 1'b0;
      pw(`FBIO_PNUM_CTRL_MODE, 16'h0003, 1);
      control_mode_vector <= 1'b1;
      motor_model_zero <= 1'b1;
      pw(`FBIO_PNUM_CTRL_MODE, 16'h0004, 1);
      pw(`FBIO_PARAM_IDLE, 16'h0005, 0);
      $display("test parameter write done");
      apb(1'b1, `FBIO_IN_W3_OFS, 32'h0000_ffff);
      apb(1'b0, 8'h30, 32'h0000_0000);
      chk("unmapped err", rerr, 32'h0000_0001);
      chk("unmapped data", rdat, 32'h0000_0000);
      apb(1'b0, `FBIO_IN_W3_OFS, 32'h0000_0000);
      chk("ro word", rdat, f_di(digital_inputs));
      $display("test bus errors done");
      motor_torque_param <= 16'h012c;
      motor_current_param <= 16'h00c8;
      apb(1'b0, `FBIO_IN_W5_OFS, 32'h0000_0000);
      chk("torque early", 32'(rdat < 150), 32'h0000_0001);
      repeat (4000) @(posedge pclk);
      apb(1'b0, `FBIO_IN_W5_OFS, 32'h0000_0000);
      chk("torque", 32'(rdat >= 298 && rdat <= 300), 32'h0000_0001);
      apb(1'b0, `FBIO_IN_W6_OFS, 32'h0000_0000);
      chk("current", 32'(rdat >= 198 && rdat <= 200), 32'h0000_0001);
      $display("test filters done");
      apb(1'b1, `FBIO_WCNT_OFS, 32'h0000_0004);
      apb(1'b0, `FBIO_IN_W5_OFS, 32'h0000_0000);
      chk("four w5", rdat, 32'h0000_0000);
      apb(1'b0, `FBIO_IN_W4_OFS, 32'h0000_0000);
      chk("four w4", rdat, 32'h0000_1234);
      $display("test four words done");
      end_of_test();
   end
endmodule : test_fieldbus_io_word_handler
